// [verilog/rsl_pkg.sv]
/*
  Constants for the reset source logic: register address, flag
  positions, reset values, timing and the sequencer states.
  Assumes a 40 MHz core clock.
*/
`default_nettype none
package rsl_pkg;
  localparam int          SFR_AW      = 8;
  localparam int          SFR_DW      = 8;
  localparam logic [7:0]  RSRC_ADDR   = 8'hEF;
  localparam int          PIN_BIT     = 0;
  localparam int          POR_BIT     = 1;
  localparam int          CLKLOSS_BIT = 2;
  localparam int          DOG_BIT     = 3;
  localparam int          SW_BIT      = 4;
  localparam int          CMP_BIT     = 5;
  localparam int          FERR_BIT    = 6;
  localparam int          NCAUSE      = 7;
  localparam logic [6:0]  FLAG_RST    = 7'h02;
  localparam logic [7:0]  RD_IDLE     = 8'h00;
  localparam int          CLK_NS      = 25;
  localparam int          RST_HOLD_NS = 100;
  localparam int          HOLD_CYC    = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int          DOG_DIV     = 12;
  localparam logic [15:0] RSVD_DFLT   = 16'h7E00;
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } rsl_state_t;
endpackage
`default_nettype wire

// [verilog/rsl_flash_if.sv]
/*
  Carrier between the top and the program-memory access guard.
  Assumes all signals are on core_clk.
*/
`default_nettype none
interface rsl_flash_if #(parameter int AW = 16);
  logic          xdataWr;
  logic          pmWrEn;
  logic          codeRd;
  logic          fetchReq;
  logic [AW-1:0] memAddr;
  logic          secDeny;
  logic          vddHigh;
  logic          vddRstEn;
  logic          flErr;
  modport guard (input xdataWr, pmWrEn, codeRd, fetchReq, memAddr,
                 secDeny, vddHigh, vddRstEn, output flErr);
  modport top   (output xdataWr, pmWrEn, codeRd, fetchReq, memAddr,
                 secDeny, vddHigh, vddRstEn, input flErr);
endinterface
`default_nettype wire

// [verilog/rsl_flash_guard.sv]
/*
  Program-memory access guard: flags an illegal or disallowed access.
  Assumes request strobes are single-cycle pulses on core_clk.
*/
`default_nettype none
module rsl_flash_guard #(
  parameter int              AW        = 16,
  parameter logic [AW-1:0]   RSVD_BASE = rsl_pkg::RSVD_DFLT[AW-1:0]
) (
  input  wire logic   core_clk,
  input  wire logic   srst,
  rsl_flash_if.guard  fl
);
  import rsl_pkg::*;
  if (RSVD_BASE == '0) begin : g_chk
    $error("Reserved base of zero leaves no user code space");
  end
  wire inRsvd   = fl.memAddr >= RSVD_BASE;
  wire flWrite  = fl.xdataWr & fl.pmWrEn;
  wire flAccess = flWrite | fl.codeRd;
  wire wrBad    = flWrite & inRsvd;
  wire rdBad    = fl.codeRd & inRsvd;
  wire fetchBad = fl.fetchReq & inRsvd;
  wire secBad   = flAccess & fl.secDeny;
  wire vddBad   = flAccess & ~(fl.vddHigh & fl.vddRstEn);
  assign fl.flErr = wrBad | rdBad | fetchBad | secBad | vddBad;

  property p_wr_rsvd;
    @(posedge core_clk) disable iff (srst)
    (fl.xdataWr && fl.pmWrEn && fl.memAddr >= RSVD_BASE) |-> fl.flErr;
  endproperty
  a_wr_rsvd: assert property (p_wr_rsvd)
    else $error("Reserved write did not flag an error");
  property p_fetch;
    @(posedge core_clk) disable iff (srst)
    (fl.fetchReq && fl.memAddr >= RSVD_BASE) |-> fl.flErr;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("Reserved fetch did not flag an error");
  property p_vdd;
    @(posedge core_clk) disable iff (srst)
    (fl.codeRd && !(fl.vddHigh && fl.vddRstEn)) |-> fl.flErr;
  endproperty
  a_vdd: assert property (p_vdd)
    else $error("Read without supply guard did not flag an error");
endmodule
`default_nettype wire

// [verilog/rsl_wdt_tick.sv]
/*
  Watchdog clock source: one tick every DOG_DIV core clocks.
  Assumes clr is high for as long as the system reset is held.
*/
`default_nettype none
module rsl_dog_tick #(
  parameter int DIV = rsl_pkg::DOG_DIV
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic clr,
  output logic      tick
);
  import rsl_pkg::*;
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  if (DIV < 2) begin : g_chk
    $error("Divider must be at least 2");
  end
  logic [CW-1:0] cnt_ff;
  wire  [CW-1:0] nxt_cnt = (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
  always_ff @(posedge core_clk) begin
    if (srst || clr) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  assign tick = (cnt_ff == LAST);

  property p_period;
    @(posedge core_clk) disable iff (srst || clr)
    tick |=> !tick [*4];
  endproperty
  a_period: assert property (p_period)
    else $error("Watchdog tick repeated too soon");
endmodule
`default_nettype wire

// [verilog/rsl_reset_source.sv]
/*
  Reset source logic: gathers pin, supply, missing-clock, comparator,
  watchdog, program-memory and software reset causes, holds the system
  in reset and records the cause in flags_ff.
  Assumes the special-function-register bus on core_clk; analog and
  pin inputs are asynchronous; all but vddMonHigh are synchronised here.
*/
`default_nettype none
module rsl_reset_source #(
  parameter int            AW        = 16,
  parameter logic [AW-1:0] RSVD_BASE = rsl_pkg::RSVD_DFLT[AW-1:0]
) (
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  input  wire logic [rsl_pkg::SFR_AW-1:0] sfrAddr,
  input  wire logic                      sfrWrEn,
  input  wire logic                      sfrRdEn,
  input  wire logic [rsl_pkg::SFR_DW-1:0] sfrWdata,
  output logic      [rsl_pkg::SFR_DW-1:0] sfrRdata,
  input  wire logic                      extRstN,
  output logic                           rstPinOut,
  output logic                           rstPinOe,
  input  wire logic                      vddMonBelow,
  input  wire logic                      vddMonHigh,
  input  wire logic                      clkLossTimeout,
  input  wire logic                      cmp0Out,
  input  wire logic                      dogOverflow,
  input  wire logic                      xdataWr,
  input  wire logic                      pmWrEn,
  input  wire logic                      codeRd,
  input  wire logic                      fetchReq,
  input  wire logic [AW-1:0]             memAddr,
  input  wire logic                      secDeny,
  output logic                           sysRst,
  output logic                           dogForceEn,
  output logic                           dogClkTick
);
  import rsl_pkg::*;
  if (AW < 8) begin : g_chk
    $error("Program address width too small");
  end

  // Pin, supply, clock detector, comparator; idle levels at reset
  localparam logic [3:0] SYNC_RST = 4'b1001;
  logic [3:0] syncA_ff;
  logic [3:0] syncB_ff;
  wire  [3:0] asyncIn = {cmp0Out, clkLossTimeout, vddMonBelow, extRstN};
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (srst) begin
        syncA_ff[i] <= SYNC_RST[i];
        syncB_ff[i] <= SYNC_RST[i];
      end else begin
        syncA_ff[i] <= asyncIn[i];
        syncB_ff[i] <= syncA_ff[i];
      end
    end
  end
  wire pinLow      = ~syncB_ff[0];
  wire vddLow      = syncB_ff[1];
  wire clkLossFire = syncB_ff[2];
  wire cmpLow      = ~syncB_ff[3];

  rsl_state_t        state_ff;
  logic [6:0]        cause_ff;
  logic [6:0]        flags_ff;
  logic [2:0]        cnt_ff;
  logic              cmpEn_ff;
  logic              clkLossEn_ff;
  logic              vddEn_ff;
  logic [SFR_DW-1:0] rdata_ff;

  rsl_flash_if #(.AW(AW)) flIf ();
  assign flIf.xdataWr  = xdataWr;
  assign flIf.pmWrEn   = pmWrEn;
  assign flIf.codeRd   = codeRd;
  assign flIf.fetchReq = fetchReq;
  assign flIf.memAddr  = memAddr;
  assign flIf.secDeny  = secDeny;
  assign flIf.vddHigh  = vddMonHigh;
  assign flIf.vddRstEn = vddEn_ff;

  rsl_flash_guard #(
    .AW        (AW),
    .RSVD_BASE (RSVD_BASE)
  ) u_guard (
    .core_clk (core_clk),
    .srst     (srst),
    .fl       (flIf)
  );

  wire running = (state_ff == ST_RUN);
  wire holding = (state_ff == ST_HOLD);
  wire regSel  = (sfrAddr == RSRC_ADDR);
  wire regWr   = running & sfrWrEn & regSel;
  wire swForce = regWr & sfrWdata[SW_BIT];

  wire pinTrig  = pinLow;
  wire porTrig  = vddEn_ff & vddLow;
  wire lossTrig = clkLossEn_ff & clkLossFire;
  wire cmpTrig  = cmpEn_ff & cmpLow;
  wire dogTrig  = dogOverflow;
  wire ferrTrig = flIf.flErr;
  wire anyTrig  = pinTrig | porTrig | lossTrig | cmpTrig |
                  dogTrig | ferrTrig | swForce;

  // One cause is kept when several fire together; pin ranks first
  logic [6:0] selCause;
  assign selCause[PIN_BIT]     = pinTrig;
  assign selCause[POR_BIT]     = ~pinTrig & porTrig;
  assign selCause[CLKLOSS_BIT] = ~|selCause[1:0] & lossTrig;
  assign selCause[CMP_BIT]     = ~|selCause[2:0] & cmpTrig;
  assign selCause[DOG_BIT]     = ~|{selCause[CMP_BIT], selCause[2:0]} &
                                 dogTrig;
  assign selCause[FERR_BIT]    = ~|{selCause[CMP_BIT], selCause[3:0]} &
                                 ferrTrig;
  assign selCause[SW_BIT]      = ~|{selCause[FERR_BIT], selCause[CMP_BIT],
                                 selCause[3:0]} & swForce;

  // Hold stretches while the pin stays low, or while the supply stays low after a supply-caused reset
  localparam logic [2:0] HOLD_LAST = 3'(HOLD_CYC - 1);
  wire holdOn  = pinLow | (vddLow & cause_ff[POR_BIT]);
  wire holdEnd = holding & (cnt_ff == '0) & ~holdOn;
  wire enter   = running & anyTrig;

  wire rsl_state_t nxt_state = enter   ? ST_HOLD :
                               holdEnd ? ST_RUN  : state_ff;
  wire [2:0] nxt_cnt = enter ? HOLD_LAST :
                       (holding && holdOn) ? HOLD_LAST :
                       (holding && cnt_ff != '0) ? cnt_ff - 3'd1 :
                       cnt_ff;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= ST_HOLD;
      cnt_ff   <= HOLD_LAST;
      cause_ff <= FLAG_RST;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      if (enter) begin
        cause_ff <= selCause;
      end
    end
  end

  // Flags change only on leaving reset, so no software clear races
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flags_ff <= FLAG_RST;
    end else if (holdEnd) begin
      flags_ff <= cause_ff;
    end
  end

  // Only enable bits are writable; read-only flags ignore writes
  always_ff @(posedge core_clk) begin
    if (srst || enter) begin
      cmpEn_ff     <= 1'b0;
      clkLossEn_ff <= 1'b0;
    end else if (regWr) begin
      cmpEn_ff     <= sfrWdata[CMP_BIT];
      clkLossEn_ff <= sfrWdata[CLKLOSS_BIT];
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      vddEn_ff <= 1'b0;
    end else if (regWr) begin
      vddEn_ff <= sfrWdata[POR_BIT];
    end
  end

  wire [SFR_DW-1:0] rdView = {1'b0, flags_ff};
  wire [SFR_DW-1:0] nxt_rdata = (sfrRdEn & regSel) ? rdView : RD_IDLE;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_ff <= RD_IDLE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign sfrRdata = rdata_ff;

  rsl_dog_tick #(
    .DIV (DOG_DIV)
  ) u_dog (
    .core_clk (core_clk),
    .srst     (srst),
    .clr      (holding),
    .tick     (dogClkTick)
  );

  assign sysRst     = holding;
  assign dogForceEn = holding;
  // Pin is input only here; internal resets never reach it
  assign rstPinOut  = 1'b0;
  assign rstPinOe   = 1'b0;

  property p_sw_force;
    @(posedge core_clk) disable iff (srst)
    (running && sfrWrEn && sfrAddr == RSRC_ADDR && sfrWdata[SW_BIT])
      |=> sysRst;
  endproperty
  a_sw_force: assert property (p_sw_force)
    else $error("Software force did not reset");
  property p_dog;
    @(posedge core_clk) disable iff (srst)
    (running && dogOverflow && !pinLow && !porTrig && !lossTrig &&
     !cmpTrig) |=> ##[4:8] (running && flags_ff[DOG_BIT]);
  endproperty
  a_dog: assert property (p_dog)
    else $error("Watchdog reset not recorded in bit 3");
  property p_ferr;
    @(posedge core_clk) disable iff (srst)
    (running && flIf.flErr && !pinLow && !porTrig && !lossTrig &&
     !cmpTrig && !dogOverflow)
      |=> ##[4:8] (running && flags_ff[FERR_BIT]);
  endproperty
  a_ferr: assert property (p_ferr)
    else $error("Memory error reset not recorded in bit 6");
  property p_pin;
    @(posedge core_clk) disable iff (srst)
    (holding && $rose(running) == 0 && pinLow) |-> ##1 sysRst;
  endproperty
  a_pin: assert property (p_pin)
    else $error("Reset released while pin still low");
  property p_pin_flag;
    @(posedge core_clk) disable iff (srst)
    $fell(sysRst) && cause_ff[PIN_BIT] |-> flags_ff[PIN_BIT];
  endproperty
  a_pin_flag: assert property (p_pin_flag)
    else $error("Pin reset flag not set on exit");
  property p_onehot;
    @(posedge core_clk) disable iff (srst)
    $fell(sysRst) |-> $onehot(flags_ff);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("More than one cause flag after reset");
  property p_bit7;
    @(posedge core_clk) disable iff (srst)
    $past(sfrRdEn && regSel) |-> (sfrRdata[7] == 1'b0);
  endproperty
  a_bit7: assert property (p_bit7)
    else $error("Unused bit read as one");
  property p_pin_quiet;
    @(posedge core_clk) disable iff (srst)
    sysRst |-> !rstPinOe;
  endproperty
  a_pin_quiet: assert property (p_pin_quiet)
    else $error("Reset pin driven by internal reset");
  property p_hold_len;
    @(posedge core_clk) disable iff (srst)
    $rose(sysRst) |-> sysRst [*4];
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("System reset shorter than hold time");
  property p_cmp_flag;
    @(posedge core_clk) disable iff (srst)
    $fell(sysRst) && cause_ff[CMP_BIT] |-> flags_ff[CMP_BIT];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag)
    else $error("Comparator reset flag not set on exit");
  property p_loss_flag;
    @(posedge core_clk) disable iff (srst)
    $fell(sysRst) && cause_ff[CLKLOSS_BIT] |-> flags_ff[CLKLOSS_BIT];
  endproperty
  a_loss_flag: assert property (p_loss_flag)
    else $error("Clock loss reset flag not set on exit");
  // Comparator and clock-loss enables must not survive a reset, or a stuck source would loop
  property p_en_clear;
    @(posedge core_clk) disable iff (srst)
    $rose(sysRst) |-> (!cmpEn_ff && !clkLossEn_ff);
  endproperty
  a_en_clear: assert property (p_en_clear)
    else $error("Source enable kept through reset");
  property p_ro_bits;
    @(posedge core_clk) disable iff (srst)
    (running && !anyTrig) |=> $stable(flags_ff);
  endproperty
  a_ro_bits: assert property (p_ro_bits)
    else $error("Cause flags changed without a reset");
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
/*
  Self-checking bench for rsl_reset_source: drives the register bus,
  the reset causes and the memory access strobes, and checks the flags.
  Assumes the top module of the design and rsl_pkg are compiled first.
*/
`default_nettype none
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin errCount++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rsl_pkg::*;
  localparam logic [15:0] RB = 16'h7E00;
  logic        core_clk, srst, sfrWrEn, sfrRdEn, extRstN, vddMonBelow;
  logic        vddMonHigh, clkLossTimeout, cmp0Out, dogOverflow, xdataWr;
  logic        pmWrEn, codeRd, fetchReq, secDeny, rstPinOut, rstPinOe;
  logic        sysRst, dogForceEn, dogClkTick, rdPend;
  logic [7:0]  sfrAddr, sfrWdata, sfrRdata, expV;
  logic [15:0] memAddr;
  logic [31:0] lfsr;
  logic [7:0]  expQ[$];
  int          errCount, checkCount, n;

  rsl_reset_source #(.AW(16), .RSVD_BASE(RB)) DUT (
    .core_clk(core_clk), .srst(srst), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .extRstN(extRstN), .rstPinOut(rstPinOut),
    .rstPinOe(rstPinOe), .vddMonBelow(vddMonBelow),
    .vddMonHigh(vddMonHigh), .clkLossTimeout(clkLossTimeout),
    .cmp0Out(cmp0Out), .dogOverflow(dogOverflow), .xdataWr(xdataWr),
    .pmWrEn(pmWrEn), .codeRd(codeRd), .fetchReq(fetchReq),
    .memAddr(memAddr), .secDeny(secDeny), .sysRst(sysRst),
    .dogForceEn(dogForceEn), .dogClkTick(dogClkTick));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [15:0] rndLow();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0] % RB;
  endfunction

  task final_report;
    if (expQ.size() != 0) errCount++;
    $display("checks=%0d errors=%0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Waits for a reset to start and end; n gives the high cycles seen
  task wait_rst;
    int k;
    k = 0;
    n = 0;
    while (sysRst !== 1'b1 && k < 12) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 12) begin
      errCount++;
      final_report();
    end
    while (sysRst === 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 300) begin
      errCount++;
      final_report();
    end
  endtask

  // Checked every cycle so that a short reset cannot slip between
  task no_rst;
    repeat (6) begin
      @(negedge core_clk);
      `CHK(sysRst, 1'b0)
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfrAddr  <= a;
    sfrWdata <= d;
    sfrWrEn  <= 1'b1;
    @(posedge core_clk);
    sfrWrEn  <= 1'b0;
  endtask

  // The expected byte is noted before the strobe; the monitor pops it
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    expQ.push_back(e);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge core_clk);
    sfrRdEn <= 1'b0;
  endtask

  task tick_chk;
    int k;
    k = 0;
    while (dogClkTick !== 1'b1 && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (dogClkTick !== 1'b1 && k < 40);
    `CHK(k, DOG_DIV)
  endtask

  // Kind bits: fetch, code read, write enable, data write
  task mem_op(input logic [3:0] kd, input logic [15:0] a,
              input logic deny, input logic hi, input logic expRst);
    @(posedge core_clk);
    {fetchReq, codeRd, pmWrEn, xdataWr} <= kd;
    memAddr    <= a;
    secDeny    <= deny;
    vddMonHigh <= hi;
    @(posedge core_clk);
    {fetchReq, codeRd, pmWrEn, xdataWr, secDeny} <= 5'h00;
    vddMonHigh <= 1'b1;
    if (expRst) begin
      wait_rst();
      `CHK(n, HOLD_CYC)
      rd(RSRC_ADDR, 8'h40);
    end else
      no_rst();
  endtask

  always @(negedge core_clk) begin
    if (rdPend) begin
      expV = (expQ.size() != 0) ? expQ.pop_front() : 8'hXX;
      `CHK(sfrRdata, expV)
    end
    rdPend = (sfrRdEn === 1'b1 && sysRst === 1'b0 && srst === 1'b0);
    `CHK(rstPinOe, 1'b0)
    `CHK(rstPinOut, 1'b0)
    `CHK(dogForceEn, sysRst)
  end

  initial begin
    lfsr = 32'hDFB23D3F;
    {srst, extRstN, vddMonHigh, cmp0Out} = 4'hF;
    {sfrWrEn, sfrRdEn, vddMonBelow, clkLossTimeout, dogOverflow} = 5'h00;
    {xdataWr, pmWrEn, codeRd, fetchReq, secDeny} = 5'h00;
    {sfrAddr, sfrWdata, memAddr} = 32'h0000_0000;
    errCount = 0;
    checkCount = 0;
    rdPend = 1'b0;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    wait_rst();
    rd(RSRC_ADDR, 8'h02);
    tick_chk();
    wr(RSRC_ADDR, 8'h10);
    wait_rst();
    `CHK(n, HOLD_CYC)
    rd(RSRC_ADDR, 8'h10);
    @(posedge core_clk);
    dogOverflow <= 1'b1;
    @(posedge core_clk);
    dogOverflow <= 1'b0;
    wait_rst();
    `CHK(n, HOLD_CYC)
    rd(RSRC_ADDR, 8'h08);
    tick_chk();
    // Read-only bits and bit 7 must neither reset nor alter flags
    wr(RSRC_ADDR, 8'hC9);
    no_rst();
    rd(RSRC_ADDR, 8'h08);
    wr(8'hEE, 8'(rndLow()) | 8'h10);
    no_rst();
    rd(8'hEE, 8'h00);
    // Supply already stable here, so enabling its reset is safe
    wr(RSRC_ADDR, 8'h02);
    no_rst();
    mem_op(4'b0001, RB, 1'b0, 1'b1, 1'b0);
    mem_op(4'b0011, rndLow(), 1'b0, 1'b1, 1'b0);
    mem_op(4'b0011, RB, 1'b0, 1'b1, 1'b1);
    mem_op(4'b0100, RB - 16'h0001, 1'b0, 1'b1, 1'b0);
    mem_op(4'b0100, RB, 1'b0, 1'b1, 1'b1);
    mem_op(4'b1000, rndLow(), 1'b0, 1'b1, 1'b0);
    mem_op(4'b1000, 16'hFFFF, 1'b0, 1'b1, 1'b1);
    mem_op(4'b0100, rndLow(), 1'b1, 1'b1, 1'b1);
    mem_op(4'b0100, rndLow(), 1'b0, 1'b0, 1'b1);
    // Comparator low while disabled must be ignored
    @(posedge core_clk);
    cmp0Out <= 1'b0;
    no_rst();
    @(posedge core_clk);
    cmp0Out <= 1'b1;
    // Let the high level pass the synchroniser before enabling
    repeat (2) @(posedge core_clk);
    wr(RSRC_ADDR, 8'h20);
    @(posedge core_clk);
    cmp0Out <= 1'b0;
    wait_rst();
    `CHK(n, HOLD_CYC)
    @(posedge core_clk);
    cmp0Out <= 1'b1;
    rd(RSRC_ADDR, 8'h20);
    wr(RSRC_ADDR, 8'h04);
    @(posedge core_clk);
    clkLossTimeout <= 1'b1;
    repeat (3) @(posedge core_clk);
    clkLossTimeout <= 1'b0;
    wait_rst();
    rd(RSRC_ADDR, 8'h04);
    @(posedge core_clk);
    extRstN <= 1'b0;
    repeat (8) @(posedge core_clk);
    extRstN <= 1'b1;
    wait_rst();
    rd(RSRC_ADDR, 8'h01);
    wr(RSRC_ADDR, 8'h02);
    @(posedge core_clk);
    vddMonBelow <= 1'b1;
    repeat (6) @(posedge core_clk);
    vddMonBelow <= 1'b0;
    wait_rst();
    rd(RSRC_ADDR, 8'h02);
    repeat (4) @(posedge core_clk);
    final_report();
  end
endmodule
`undef CHK
`default_nettype wire
